/* inc/acc_pkg.sv */
/*
  Package for the comparator control block: register offsets, bit
  positions, reset values, event-select codes and the result latency.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package acc_pkg;

  // data-space offsets and the distance of the I/O-instruction window
  localparam logic [7:0] CTRL_STATUS_OFS  = 8'h50;
  localparam logic [7:0] PIN_DISABLE_OFS  = 8'h7f;
  localparam logic [7:0] IO_SPACE_SHIFT   = 8'h20;
  localparam logic [7:0] IO_SPACE_LAST    = 8'h3f;
  localparam logic [7:0] EXT_IO_FIRST     = 8'h60;

  // control/status bit positions
  localparam int BIT_POWER_OFF    = 7;
  localparam int BIT_BANDGAP_SEL  = 6;
  localparam int BIT_RESULT       = 5;
  localparam int BIT_EVENT_FLAG   = 4;
  localparam int BIT_IRQ_ENABLE   = 3;
  localparam int BIT_CAPTURE_EN   = 2;
  localparam int BIT_EVSEL_HIGH   = 1;
  localparam int BIT_EVSEL_LOW    = 0;

  // digital-input-disable bit positions
  localparam int BIT_POS_PIN_OFF  = 0;
  localparam int BIT_NEG_PIN_OFF  = 1;

  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [1:0] PIN_DISABLE_RESET = 2'h0;

  // event-select codes
  localparam logic [1:0] EVSEL_TOGGLE   = 2'h0;
  localparam logic [1:0] EVSEL_RESERVED = 2'h1;
  localparam logic [1:0] EVSEL_FALLING  = 2'h2;
  localparam logic [1:0] EVSEL_RISING   = 2'h3;

  // flip-flops between the raw comparator and the result bit
  localparam int SYNC_STAGES = 2;

  // true when code selects the event seen between prev and cur
  function automatic logic acc_event_hit(input logic [1:0] code,
                                         input logic       prev,
                                         input logic       cur);
    case (code)
      EVSEL_TOGGLE:  acc_event_hit = prev ^ cur;
      EVSEL_FALLING: acc_event_hit = prev & ~cur;
      EVSEL_RISING:  acc_event_hit = ~prev & cur;
      default:       acc_event_hit = 1'b0;
    endcase
  endfunction

endpackage

/* verilog/acc_sync.sv */
/*
  Two-flop synchroniser for the comparator level.
  Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/10ps
module acc_sync
  import acc_pkg::*;
(
  input  wire logic clk_i,   // system clock
  input  wire logic rst_i,   // synchronous reset, high
  input  wire logic async_i, // raw level
  output logic      sync_o   // synchronised level
);

  logic meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

/* verilog/acc_top.sv */
/*
  Comparator control: input selection, result synchroniser, event
  detection, event flag and interrupt request, capture routing and
  the pin digital-input disables, with the register port of the core.
  Assumes the analog comparator, input mux and converter live outside
  and that the core gives a one-cycle strobe for each register access.
*/
// Overview of operation
// [R1] Result high when selected positive input exceeds selected negative input.
// [R2] Raw comparator passes a synchroniser; result bit lags one to two cycles.
// [R3] Event select: 00 toggle, 01 reserved, 10 falling, 11 rising.
// [R4] Event flag sets when the synchronised result shows the chosen event.
// [R5] Flag clears on interrupt vector taken, or when software writes one.
// [R6] Interrupt requested only with flag, enable and global enable all set.
// [R7] Writing power-off bit one switches comparator power off, any time.
// [R8] Software clears interrupt enable before changing the power-off bit.
// [R9] Software clears interrupt enable before changing the event select bits.
// [R10] Bandgap select one routes bandgap to positive input, else positive pin.
// [R11] Capture route enable feeds result to timer capture, else no connection.
// [R12] Software also enables the timer capture interrupt for capture interrupts.
// [R13] Mux enable and converter off: channel select picks negative channel 0..7.
// [R14] Otherwise the dedicated negative pin drives the negative input.
// [R15] Software keeps converter power-reduce zero and converter off for the mux.
// [R16] Pin disable bit one turns off its buffer; port bit reads zero.
// [R17] Software sets pin disable bits on analog-only comparator pins.
// [R18] Control register decoded at data offset and at offset minus 0x20 for I/O.
// [R19] Extended I/O registers from 0x60 reachable only by data-space access.
// [R20] Events from current versus previous sample; none with reserved code.
// [R21] Writes to result bit and reserved disable bits ignored; reserved reads zero.
`timescale 1ns/10ps
module acc_top
  import acc_pkg::*;
(
  input  wire logic       clk_i,             // system clock, 100 MHz
  input  wire logic       rst_i,             // synchronous reset, high
  input  wire logic [7:0] addr_i,            // register address
  input  wire logic       io_space_i,        // 1: I/O instr, 0: data space
  input  wire logic       wr_i,              // write strobe
  input  wire logic       rd_i,              // read strobe
  input  wire logic [7:0] wdata_i,           // write data
  output logic      [7:0] rdata_o,           // read data, valid after rd
  output logic            rvalid_o,          // read data valid pulse
  input  wire logic       global_irq_en_i,   // processor global enable
  input  wire logic       irq_ack_i,         // vector taken pulse
  output logic            irq_o,             // interrupt request
  input  wire logic       comp_raw_i,        // analog comparator output
  input  wire logic       converter_enable_i, // converter running
  input  wire logic       negative_mux_enable_i, // mux to negative input
  input  wire logic [2:0] channel_select_i,  // converter channel field
  input  wire logic       pos_pin_level_i,   // positive pin digital level
  input  wire logic       neg_pin_level_i,   // negative pin digital level
  output logic            comparator_power_off_o, // comparator power gate
  output logic            bandgap_positive_select_o, // positive src select
  output logic            neg_use_channel_o, // 1: negative from mux
  output logic      [2:0] neg_channel_o,     // channel to negative input
  output logic            capture_trigger_o, // to timer capture front end
  output logic            positive_pin_digital_off_o, // buffer off
  output logic            negative_pin_digital_off_o, // buffer off
  output logic            pos_pin_port_o,    // port bit, gated
  output logic            neg_pin_port_o     // port bit, gated
);

  // control/status and pin-disable fields, event history and pin synchronisers
  logic       power_off;
  logic       bandgap_sel;
  logic       event_flag;
  logic       irq_enable;
  logic       capture_en;
  logic [1:0] event_select;
  logic [1:0] pin_off;
  logic       prev_sample;
  logic       compare_result;
  logic       pos_pin_s1, pos_pin_s2;
  logic       neg_pin_s1, neg_pin_s2;

  acc_sync u_sync ( // R2
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (comp_raw_i),
    .sync_o  (compare_result)
  );

  // address decode: control reg in both spaces, disable reg data only;
  // an I/O access reaches only offsets below the extended range
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic       io,
                                   input logic [7:0] ofs);
    logic [8:0] data_addr;
    logic       reachable;
    data_addr = {1'b0, addr} + (io ? {1'b0, IO_SPACE_SHIFT} : 9'h000);
    reachable = ~io | (addr <= IO_SPACE_LAST && ofs < EXT_IO_FIRST);
    reg_hit   = reachable && data_addr == {1'b0, ofs};
  endfunction

  wire       hit_ctrl    = reg_hit(addr_i, io_space_i, CTRL_STATUS_OFS); // R18
  wire       hit_dis     = reg_hit(addr_i, io_space_i, PIN_DISABLE_OFS); // R19
  wire       wr_ctrl     = wr_i & hit_ctrl;
  wire       wr_dis      = wr_i & hit_dis;

  // the reserved select code matches no event
  wire       event_hit = acc_event_hit(event_select, prev_sample,
                                       compare_result); // R20
  wire       flag_clr  = irq_ack_i |
                         (wr_ctrl & wdata_i[BIT_EVENT_FLAG]); // R5
  // a set beats a clear in the same cycle, so no event is lost
  wire       next_flag = event_hit | (event_flag & ~flag_clr); // R4

  // read images; the result bit is the synchronised level
  wire [7:0] ctrl_view = {power_off, bandgap_sel, compare_result,
                          event_flag, irq_enable, capture_en,
                          event_select};
  wire [7:0] dis_view  = {6'h00, pin_off}; // R21
  wire [7:0] next_rdata = hit_ctrl ? ctrl_view :
                          hit_dis  ? dis_view  : 8'h00;

  // negative input mux
  wire       next_use_chan = negative_mux_enable_i &
                             ~converter_enable_i; // R13 R14

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_off    <= CTRL_STATUS_RESET[BIT_POWER_OFF];
      bandgap_sel  <= CTRL_STATUS_RESET[BIT_BANDGAP_SEL];
      irq_enable   <= CTRL_STATUS_RESET[BIT_IRQ_ENABLE];
      capture_en   <= CTRL_STATUS_RESET[BIT_CAPTURE_EN];
      event_select <= CTRL_STATUS_RESET[BIT_EVSEL_HIGH:BIT_EVSEL_LOW];
    end else if (wr_ctrl) begin
      // result bit is read-only: not stored
      power_off    <= wdata_i[BIT_POWER_OFF]; // R7
      bandgap_sel  <= wdata_i[BIT_BANDGAP_SEL]; // R10
      irq_enable   <= wdata_i[BIT_IRQ_ENABLE]; // R6
      capture_en   <= wdata_i[BIT_CAPTURE_EN]; // R11
      event_select <= wdata_i[BIT_EVSEL_HIGH:BIT_EVSEL_LOW]; // R3
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_flag  <= CTRL_STATUS_RESET[BIT_EVENT_FLAG];
      prev_sample <= 1'b0;
      pin_off     <= PIN_DISABLE_RESET;
    end else begin
      event_flag  <= next_flag;
      prev_sample <= compare_result;
      if (wr_dis) begin
        pin_off <= wdata_i[BIT_NEG_PIN_OFF:BIT_POS_PIN_OFF]; // R21
      end
    end
  end

  // pin levels come from outside: two flops first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_pin_s1 <= 1'b0;
      pos_pin_s2 <= 1'b0;
      neg_pin_s1 <= 1'b0;
      neg_pin_s2 <= 1'b0;
    end else begin
      pos_pin_s1 <= pos_pin_level_i;
      pos_pin_s2 <= pos_pin_s1;
      neg_pin_s1 <= neg_pin_level_i;
      neg_pin_s2 <= neg_pin_s1;
    end
  end

  // next values of the registered outputs
  wire       next_irq      = next_flag & irq_enable & global_irq_en_i &
                             ~irq_ack_i; // R6
  wire       next_capture  = capture_en & compare_result; // R11
  wire       next_pos_port = pos_pin_s2 & ~pin_off[BIT_POS_PIN_OFF]; // R16
  wire       next_neg_port = neg_pin_s2 & ~pin_off[BIT_NEG_PIN_OFF]; // R16

  // read port: data stands only in the rvalid_o cycle, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= rd_i ? next_rdata : 8'h00; // R18
      rvalid_o <= rd_i;
    end
  end

  // request drops in the ack cycle so the vector is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o             <= 1'b0;
      capture_trigger_o <= 1'b0;
    end else begin
      irq_o             <= next_irq; // R6
      capture_trigger_o <= next_capture; // R11
    end
  end

  // analog side: power gate and input selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_power_off_o    <= 1'b0;
      bandgap_positive_select_o <= 1'b0;
      neg_use_channel_o         <= 1'b0;
      neg_channel_o             <= 3'h0;
    end else begin
      comparator_power_off_o    <= power_off; // R7
      bandgap_positive_select_o <= bandgap_sel; // R1 R10
      neg_use_channel_o         <= next_use_chan; // R14
      neg_channel_o             <= channel_select_i; // R13
    end
  end

  // pin input buffers and the gated port bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      positive_pin_digital_off_o <= 1'b0;
      negative_pin_digital_off_o <= 1'b0;
      pos_pin_port_o             <= 1'b0;
      neg_pin_port_o             <= 1'b0;
    end else begin
      positive_pin_digital_off_o <= pin_off[BIT_POS_PIN_OFF]; // R16
      negative_pin_digital_off_o <= pin_off[BIT_NEG_PIN_OFF]; // R16
      pos_pin_port_o             <= next_pos_port; // R16
      neg_pin_port_o             <= next_neg_port; // R16
    end
  end

endmodule

/* sim/acc_props.sv */
/* assertions on the acc_top ports
   bound into acc_top; one clock, synchronous high reset */
`timescale 1ns/10ps
module acc_props (
  input wire logic       clk_i,                     // clock
  input wire logic       rst_i,                     // reset
  input wire logic [7:0] addr_i,                    // address
  input wire logic       io_space_i,                // io access
  input wire logic       wr_i,                      // write
  input wire logic       rd_i,                      // read
  input wire logic [7:0] wdata_i,                   // wdata
  input wire logic [7:0] rdata_o,                   // rdata
  input wire logic       rvalid_o,                  // valid
  input wire logic       global_irq_en_i,           // gie
  input wire logic       irq_o,                     // request
  input wire logic       comp_raw_i,                // raw
  input wire logic       converter_enable_i,        // conv on
  input wire logic       negative_mux_enable_i,     // mux on
  input wire logic [2:0] channel_select_i,          // chan in
  input wire logic       comparator_power_off_o,    // power
  input wire logic       bandgap_positive_select_o, // bandgap
  input wire logic       neg_use_channel_o,         // mux used
  input wire logic [2:0] neg_channel_o,             // chan out
  input wire logic       capture_trigger_o          // capture
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire       ctrl_wr = wr_i && (io_space_i ? addr_i == 8'h30
                                           : addr_i == 8'h50);
  wire [1:0] top2    = wdata_i[7:6];
  wire       use_mux = negative_mux_enable_i && !converter_enable_i;
  sequence s_raw_low;
    !comp_raw_i [*4];
  endsequence
  sequence s_quiet;
    ($stable(comp_raw_i) && $stable(global_irq_en_i) && !wr_i) [*6];
  endsequence
  property p_rv; !$past(rst_i) |-> rvalid_o == $past(rd_i); endproperty
  property p_io; rd_i && io_space_i && addr_i == 8'h5f |=> rdata_o == 8'h00;
  endproperty
  property p_pwr; ctrl_wr |-> ##2
    {comparator_power_off_o, bandgap_positive_select_o} == $past(top2, 2);
  endproperty
  property p_mux; !$past(rst_i) |-> neg_use_channel_o == $past(use_mux);
  endproperty
  property p_chan; !$past(rst_i) |-> neg_channel_o == $past(channel_select_i);
  endproperty
  property p_cap; s_raw_low |=> !capture_trigger_o; endproperty
  property p_noev; s_quiet |=> !$rose(irq_o); endproperty
  property p_gie; irq_o |-> $past(global_irq_en_i); endproperty
  a_rv: assert property (p_rv) else $error("read valid lag wrong");
  a_io: assert property (p_io) else $error("io read leaked data");
  a_pwr: assert property (p_pwr) else $error("control bits wrong");
  a_mux: assert property (p_mux) else $error("mux select wrong");
  a_chan: assert property (p_chan) else $error("channel wrong");
  a_cap: assert property (p_cap) else $error("capture without result");
  a_noev: assert property (p_noev) else $error("event with no change");
  a_gie: assert property (p_gie) else $error("irq without global");
endmodule
bind acc_top acc_props u_props (.clk_i, .rst_i, .addr_i, .io_space_i, .wr_i,
  .rd_i, .wdata_i, .rdata_o, .rvalid_o, .global_irq_en_i, .irq_o, .comp_raw_i,
  .converter_enable_i, .negative_mux_enable_i, .channel_select_i,
  .comparator_power_off_o, .bandgap_positive_select_o, .neg_use_channel_o,
  .neg_channel_o, .capture_trigger_o);

/* sim/acc_analog.sv */
/* behavioural analog side: comparator, bandgap and channel mux
   millivolt levels are set by the bench through hierarchy */
`timescale 1ns/10ps
module acc_analog (
  input  wire logic       off_i,  // power gate
  input  wire logic       bg_i,   // bandgap select
  input  wire logic       chan_i, // mux in use
  input  wire logic [2:0] sel_i,  // channel
  output logic            comp_o  // raw result
);
  int pos_mv = 0;
  int neg_mv = 0;
  int bg_mv  = 0;
  int ch_mv [8];
  always_comb begin
    comp_o = !off_i && (bg_i ? bg_mv : pos_mv) >
             (chan_i ? ch_mv[sel_i] : neg_mv);
  end
endmodule

/* sim/tb.sv */
/* self-checking bench for acc_top and the analog model
   inputs move on the falling edge; read results are queued */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: %h %h", $time, (a), (b)); end end
module tb;
  import acc_pkg::*;
  logic clk_i = 0, rst_i = 1, io_space_i = 0, wr_i = 0, rd_i = 0;
  logic global_irq_en_i = 0, irq_ack_i = 0, comp_raw_i, irq_o, rvalid_o;
  logic converter_enable_i = 0, negative_mux_enable_i = 0;
  logic pos_pin_level_i = 0, neg_pin_level_i = 0, neg_use_channel_o;
  logic comparator_power_off_o, bandgap_positive_select_o, f;
  logic capture_trigger_o, pos_pin_port_o, neg_pin_port_o;
  logic positive_pin_digital_off_o, negative_pin_digital_off_o;
  logic [2:0] channel_select_i = 0, neg_channel_o;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, e;
  logic [7:0] expq[$];
  int errors = 0, checks = 0, cyc = 0, seed = 32'hdd30c0b7;
  acc_top dut (.clk_i, .rst_i, .addr_i, .io_space_i, .wr_i, .rd_i,
    .wdata_i, .rdata_o, .rvalid_o, .global_irq_en_i, .irq_ack_i, .irq_o,
    .comp_raw_i, .converter_enable_i, .negative_mux_enable_i,
    .channel_select_i, .pos_pin_level_i, .neg_pin_level_i,
    .comparator_power_off_o, .bandgap_positive_select_o,
    .neg_use_channel_o, .neg_channel_o, .capture_trigger_o,
    .positive_pin_digital_off_o, .negative_pin_digital_off_o,
    .pos_pin_port_o, .neg_pin_port_o);
  acc_analog u_ana (.off_i(comparator_power_off_o),
    .bg_i(bandgap_positive_select_o), .chan_i(neg_use_channel_o),
    .sel_i(neg_channel_o), .comp_o(comp_raw_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop;
    end
  end
  always @(negedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      e = expq.pop_front();
      `CHK(rdata_o, e)
    end
  end
  task automatic acc(input bit w, io, input logic [7:0] a, d);
    @(negedge clk_i);
    {wr_i, rd_i, io_space_i, addr_i, wdata_i} = {w, !w, io, a, d};
    @(negedge clk_i);
    {wr_i, rd_i} = 2'b00;
  endtask
  task automatic rd(input bit io, input logic [7:0] a, x);
    expq.push_back(x);
    acc(0, io, a, 8'h00);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    wt(8);
    rst_i = 0;
    rd(0, 8'h50, 8'h00);
    acc(1, 0, 8'h7f, 8'hff);
    rd(0, 8'h7f, 8'h03);
    rd(1, 8'h5f, 8'h00);
    rd(0, 8'h51, 8'h00);
    pos_pin_level_i = 1;
    neg_pin_level_i = 1;
    wt(3);
    `CHK(pos_pin_port_o, 1'b0)
    `CHK(neg_pin_port_o, 1'b0)
    `CHK(positive_pin_digital_off_o, 1'b1)
    `CHK(negative_pin_digital_off_o, 1'b1)
    acc(1, 0, 8'h7f, 8'h00);
    u_ana.neg_mv = 200;
    u_ana.bg_mv = 300;
    acc(1, 1, 8'h30, 8'he0);
    wt(4);
    rd(0, 8'h50, 8'hc0);
    acc(1, 0, 8'h50, 8'h40);
    wt(4);
    rd(1, 8'h30, 8'h70);
    acc(1, 0, 8'h50, 8'h10);
    global_irq_en_i = 1;
    for (int c = 0; c < 4; c++) begin
      u_ana.pos_mv = 100;
      wt(6);
      acc(1, 0, 8'h50, {6'h04, c[1:0]});
      acc(1, 0, 8'h50, {6'h06, c[1:0]});
      u_ana.pos_mv = 400;
      wt(6);
      f = c == 0 || c == 3;
      `CHK(irq_o, f)
      rd(0, 8'h50, {3'h1, f, 2'h2, c[1:0]});
      irq_ack_i = 1;
      wt(1);
      irq_ack_i = 0;
      wt(1);
      `CHK(irq_o, 1'b0)
      u_ana.pos_mv = 100;
      wt(6);
      f = c == 0 || c == 2;
      `CHK(irq_o, f)
      global_irq_en_i = 0;
      wt(2);
      `CHK(irq_o, 1'b0)
      global_irq_en_i = 1;
      acc(1, 0, 8'h50, {6'h06, c[1:0]});
      wt(2);
      `CHK(irq_o, 1'b0)
    end
    acc(1, 0, 8'h50, 8'h15);
    u_ana.pos_mv = 200;
    for (int i = 0; i < 16; i++) begin
      {negative_mux_enable_i, converter_enable_i, channel_select_i} =
        5'($random(seed));
      pos_pin_level_i = 1'($random(seed));
      neg_pin_level_i = 1'($random(seed));
      for (int k = 0; k < 8; k++)
        u_ana.ch_mv[k] = $unsigned($random(seed)) % 400;
      wt(6);
      f = negative_mux_enable_i && !converter_enable_i &&
          u_ana.ch_mv[channel_select_i] < 200;
      `CHK(capture_trigger_o, f)
      `CHK(pos_pin_port_o, pos_pin_level_i)
      `CHK(neg_pin_port_o, neg_pin_level_i)
      `CHK(positive_pin_digital_off_o, 1'b0)
      rd(0, 8'h50, {2'h0, f, 5'h05});
    end
    wt(4);
    `CHK(expq.size(), 0)
    report_and_stop;
  end
endmodule
